// ==== rtl/tiw_pkg.sv ====
// Constants shared by the timer, interrupt and watchdog unit
package tiw_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [7:0] TIW_ADDR_MODE     = 8'hF1;
	localparam logic [7:0] TIW_ADDR_CNT1     = 8'hF2;
	localparam logic [7:0] TIW_ADDR_COUNTER_ONE_PRESCALE     = 8'hF3;
	localparam logic [7:0] TIW_ADDR_CNT0     = 8'hF4;
	localparam logic [7:0] TIW_ADDR_COUNTER_ZERO_PRESCALE     = 8'hF5;
	localparam logic [7:0] TIW_ADDR_PRIO     = 8'hF9;
	localparam logic [7:0] TIW_ADDR_REQ      = 8'hFA;
	localparam logic [7:0] TIW_ADDR_MASK     = 8'hFB;
	// ==========================================================
	// Timer mode control fields
	localparam int TIW_MODE_LOAD0  = 0;
	localparam int TIW_MODE_RUN0   = 1;
	localparam int TIW_MODE_LOAD1  = 2;
	localparam int TIW_MODE_RUN1   = 3;
	localparam int TIW_MODE_IN_LO  = 4;
	localparam int TIW_MODE_OUT_LO = 6;
	// Prescale register fields
	localparam int TIW_PRE_CONT    = 0;
	localparam int TIW_PRE_INTCLK  = 1;
	localparam int TIW_PRE_DIV_LO  = 2;
	// Mask register global enable bit
	localparam int TIW_MASK_GLOBAL = 7;
	// ==========================================================
	// Reset values
	localparam logic [7:0] TIW_MODE_RST = 8'h00;
	localparam logic [7:0] TIW_REQ_RST  = 8'h00;
	localparam logic [7:0] TIW_MASK_RST = 8'h00;
	// ==========================================================
	// Timing
	localparam int TIW_CLK_HZ      = 10_000_000;
	localparam int TIW_POR_MS      = 40;
	localparam int TIW_WDT_MS      = 10;
	localparam int TIW_POR_CYCLES  = TIW_CLK_HZ / 1000 * TIW_POR_MS;
	localparam int TIW_WDT_CYCLES  = TIW_CLK_HZ / 1000 * TIW_WDT_MS;
	localparam int TIW_INT_DIV     = 4;
	localparam logic [7:0] TIW_WDT_OPCODE = 8'h5F;
	localparam int TIW_NUM_REQ     = 6;
	// ==========================================================
	// External input selections for counter one
	typedef enum logic [1:0] {
		TIW_IN_EXT_CLK  = 2'b00,
		TIW_IN_GATE     = 2'b01,
		TIW_IN_TRIG_NR  = 2'b11,
		TIW_IN_TRIG_RT  = 2'b10
	} tiw_in_mode_e;
	// Timer output selections
	typedef enum logic [1:0] {
		TIW_OUT_CNT1  = 2'b00,
		TIW_OUT_CNT0  = 2'b01,
		TIW_OUT_CLK   = 2'b11,
		TIW_OUT_OFF   = 2'b10
	} tiw_out_sel_e;
endpackage

// ==== rtl/tiw_counter.sv ====
// One prescaled 8-bit down-counter
`timescale 1ns/100ps
`default_nettype none
module tiw_counter
	import tiw_pkg::*;
#(
	parameter int PRE_W = 6,
	parameter int CNT_W = 8
) (
	input  wire logic             clock_i,
	input  wire logic             rst_b_i,
	input  wire logic             tick_i,
	input  wire logic             run_i,
	input  wire logic             load_i,
	input  wire logic             cont_i,
	input  wire logic [PRE_W-1:0] div_i,
	input  wire logic [CNT_W-1:0] init_i,
	output logic      [CNT_W-1:0] count_o,
	output logic                  end_o,
	output logic                  toggle_o
);
	initial begin
		if (PRE_W < 1 || CNT_W < 1) begin
			$error("tiw_counter: widths must be positive");
		end
	end

	logic [PRE_W-1:0] pre_r;
	logic             active_r;

	// ==========================================================
	// Prescaler: div 0 stands for the full range
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_r <= '0;
		end else if (load_i) begin
			pre_r <= div_i - PRE_W'(1);
		end else if (active_r && tick_i) begin
			pre_r <= (pre_r == '0) ? div_i - PRE_W'(1) : pre_r - PRE_W'(1);
		end
	end

	// ==========================================================
	// Counter; load value 0 means full range
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_o  <= '0;
			active_r <= 1'b0;
			end_o    <= 1'b0;
			toggle_o <= 1'b0;
		end else begin
			end_o <= 1'b0;
			if (load_i) begin
				count_o  <= init_i;
				active_r <= run_i;
			end else begin
				if (!run_i) begin
					active_r <= 1'b0;
				end else if (!active_r && count_o != '0) begin
					active_r <= 1'b1;
				end
				if (active_r && tick_i && pre_r == '0) begin
					count_o <= count_o - CNT_W'(1);
					if (count_o == CNT_W'(1)) begin
						end_o    <= 1'b1;
						toggle_o <= ~toggle_o;
						if (cont_i) begin
							count_o <= init_i;
						end else begin
							active_r <= 1'b0;
						end
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/tiw_intc.sv ====
// Interrupt request latch, mask and priority select
`timescale 1ns/100ps
`default_nettype none
module tiw_intc
	import tiw_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	input  wire logic [5:0] set_i,
	input  wire logic [5:0] sw_clr_i,
	input  wire logic       sw_wr_i,
	input  wire logic [5:0] sw_data_i,
	input  wire logic [7:0] mask_i,
	input  wire logic [5:0] prio_i,
	input  wire logic       ack_i,
	output logic      [5:0] req_o,
	output logic            irq_o,
	output logic      [2:0] id_o,
	output logic      [3:0] vector_o
);
	logic [5:0] req_nxt;
	logic [5:0] live;
	logic [2:0] pick;
	logic       any;

	// Fixed rotation of the six requests chosen by priority bits
	function automatic logic [2:0] tiw_choose(input logic [5:0] p, input logic [5:0] v);
		logic [2:0] r;
		r = 3'd0;
		for (int i = TIW_NUM_REQ - 1; i >= 0; i--) begin
			if (v[(i + int'(p[2:0])) % TIW_NUM_REQ]) begin
				r = 3'((i + int'(p[2:0])) % TIW_NUM_REQ);
			end
		end
		return r;
	endfunction

	always_comb begin
		live = req_o & mask_i[5:0] & {6{mask_i[TIW_MASK_GLOBAL]}};
		any  = |live;
		pick = tiw_choose(prio_i, live);
		req_nxt = req_o;
		if (sw_wr_i) begin
			req_nxt = sw_data_i;
		end
		req_nxt = req_nxt & ~sw_clr_i;
		if (ack_i) begin
			req_nxt[id_o] = 1'b0;
		end
		req_nxt = req_nxt | set_i;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			req_o    <= TIW_REQ_RST[5:0];
			irq_o    <= 1'b0;
			id_o     <= 3'd0;
			vector_o <= 4'd0;
		end else begin
			req_o    <= req_nxt;
			irq_o    <= any && !ack_i;
			id_o     <= pick;
			vector_o <= {pick, 1'b0};
		end
	end
endmodule
`default_nettype wire

// ==== rtl/tiw_top.sv ====
// Timer, interrupt and watchdog unit top level
`timescale 1ns/100ps
`default_nettype none
module tiw_top
	import tiw_pkg::*;
#(
	parameter int POR_CYCLES = TIW_POR_CYCLES,
	parameter int WDT_CYCLES = TIW_WDT_CYCLES
) (
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic [7:0] opcode_i,
	input  wire logic       opcode_valid_i,
	input  wire logic       int_ack_i,
	input  wire logic       port3_line_one_i,
	input  wire logic       port3_line_two_i,
	input  wire logic       port3_line_three_i,
	output logic            port3_line_six_o,
	output logic            int_req_o,
	output logic      [3:0] int_vector_o,
	output logic            int_disable_o,
	output logic            core_hold_o,
	output logic            sys_reset_o
);
	initial begin
		if (POR_CYCLES < 1 || WDT_CYCLES < 1) begin
			$error("tiw_top: counts must be at least one");
		end
	end

	// ==========================================================
	// Registers
	logic [7:0] mode_r;
	logic [7:0] counter_zero_prescale_r;
	logic [7:0] counter_one_prescale_r;
	logic [7:0] init0_r;
	logic [7:0] init1_r;
	logic [7:0] mask_r;
	logic [5:0] prio_r;
	logic       load0_p;
	logic       load1_p;
	logic       req_wr_p;
	logic       soft_rst;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_r   <= TIW_MODE_RST;
			counter_zero_prescale_r   <= 8'h00;
			counter_one_prescale_r   <= 8'h00;
			init0_r  <= 8'h00;
			init1_r  <= 8'h00;
			mask_r   <= TIW_MASK_RST;
			prio_r   <= 6'h00;
			load0_p  <= 1'b0;
			load1_p  <= 1'b0;
			req_wr_p <= 1'b0;
		end else if (soft_rst) begin
			mode_r   <= TIW_MODE_RST;
			mask_r   <= TIW_MASK_RST;
			load0_p  <= 1'b0;
			load1_p  <= 1'b0;
			req_wr_p <= 1'b0;
		end else begin
			load0_p  <= 1'b0;
			load1_p  <= 1'b0;
			req_wr_p <= 1'b0;
			if (int_ack_i) begin
				mask_r[TIW_MASK_GLOBAL] <= 1'b0;
			end
			if (reg_wr_i) begin
				if (reg_addr_i == TIW_ADDR_MODE) begin
					mode_r  <= reg_wdata_i;
					load0_p <= reg_wdata_i[TIW_MODE_LOAD0];
					load1_p <= reg_wdata_i[TIW_MODE_LOAD1];
				end else if (reg_addr_i == TIW_ADDR_CNT1) begin
					init1_r <= reg_wdata_i;
				end else if (reg_addr_i == TIW_ADDR_COUNTER_ONE_PRESCALE) begin
					counter_one_prescale_r <= reg_wdata_i;
				end else if (reg_addr_i == TIW_ADDR_CNT0) begin
					init0_r <= reg_wdata_i;
				end else if (reg_addr_i == TIW_ADDR_COUNTER_ZERO_PRESCALE) begin
					counter_zero_prescale_r <= reg_wdata_i;
				end else if (reg_addr_i == TIW_ADDR_PRIO) begin
					prio_r <= reg_wdata_i[5:0];
				end else if (reg_addr_i == TIW_ADDR_REQ) begin
					req_wr_p <= 1'b1;
				end else if (reg_addr_i == TIW_ADDR_MASK) begin
					mask_r <= reg_wdata_i;
				end
			end
		end
	end

	// ==========================================================
	// Pin synchronisers: change accepted when stages two and three agree
	logic [2:0] pin_raw;
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;
	logic [2:0] pin_r;
	logic [2:0] pin_d_r;

	assign pin_raw = {port3_line_three_i, port3_line_two_i, port3_line_one_i};

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r    <= 3'b111;
			s2_r    <= 3'b111;
			s3_r    <= 3'b111;
			pin_r   <= 3'b111;
			pin_d_r <= 3'b111;
		end else begin
			s1_r    <= pin_raw;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			pin_r   <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
			pin_d_r <= pin_r;
		end
	end

	logic [2:0] fall;
	logic       rise_two;
	assign fall     = pin_d_r & ~pin_r;
	assign rise_two = ~pin_d_r[1] & pin_r[1];

	// ==========================================================
	// Internal clock: processor clock divided by four
	logic [1:0] div4_r;
	logic       int_tick;
	logic       int_clk_r;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div4_r    <= 2'd0;
			int_clk_r <= 1'b0;
		end else begin
			div4_r <= div4_r + 2'd1;
			if (div4_r[0]) begin
				int_clk_r <= ~int_clk_r;
			end
		end
	end
	assign int_tick = (div4_r == 2'(TIW_INT_DIV - 1));

	// ==========================================================
	// Counter one input conditioning
	tiw_in_mode_e in_mode;
	logic         gate_open_r;
	logic         trig_fire;
	logic         tick1;
	logic         run1;
	logic         load1_any;
	logic         end0;
	logic         end1;
	logic         tog0;
	logic         tog1;
	logic [7:0]   cnt0;
	logic [7:0]   cnt1;
	logic         c1_busy_r;

	assign in_mode = tiw_in_mode_e'(mode_r[TIW_MODE_IN_LO +: 2]);

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c1_busy_r <= 1'b0;
		end else if (load1_any) begin
			c1_busy_r <= 1'b1;
		end else if (end1 && !counter_one_prescale_r[TIW_PRE_CONT]) begin
			c1_busy_r <= 1'b0;
		end
	end

	always_comb begin
		gate_open_r = pin_r[0];
		trig_fire   = 1'b0;
		if (in_mode == TIW_IN_TRIG_RT) begin
			trig_fire = fall[0];
		end else if (in_mode == TIW_IN_TRIG_NR) begin
			trig_fire = fall[0] && !c1_busy_r;
		end
		if (!counter_one_prescale_r[TIW_PRE_INTCLK] && in_mode == TIW_IN_EXT_CLK) begin
			tick1 = fall[0];
		end else if (!counter_one_prescale_r[TIW_PRE_INTCLK] && in_mode == TIW_IN_GATE) begin
			tick1 = int_tick && gate_open_r;
		end else if (!counter_one_prescale_r[TIW_PRE_INTCLK]) begin
			tick1 = int_tick;
		end else if (mode_r[TIW_MODE_OUT_LO +: 2] == TIW_OUT_CNT0) begin
			tick1 = end0;
		end else begin
			tick1 = int_tick;
		end
	end

	assign load1_any = load1_p || (mode_r[TIW_MODE_RUN1] && trig_fire);
	assign run1      = mode_r[TIW_MODE_RUN1];

	// ==========================================================
	// Counters
	tiw_counter #(
		.PRE_W (6),
		.CNT_W (8)
	) u_counter_zero (
		.clock_i  (clock_i),
		.rst_b_i  (rst_b_i),
		.tick_i   (int_tick),
		.run_i    (mode_r[TIW_MODE_RUN0]),
		.load_i   (load0_p),
		.cont_i   (counter_zero_prescale_r[TIW_PRE_CONT]),
		.div_i    (counter_zero_prescale_r[7:TIW_PRE_DIV_LO]),
		.init_i   (init0_r),
		.count_o  (cnt0),
		.end_o    (end0),
		.toggle_o (tog0)
	);

	tiw_counter #(
		.PRE_W (6),
		.CNT_W (8)
	) u_counter_one (
		.clock_i  (clock_i),
		.rst_b_i  (rst_b_i),
		.tick_i   (tick1),
		.run_i    (run1),
		.load_i   (load1_any),
		.cont_i   (counter_one_prescale_r[TIW_PRE_CONT]),
		.div_i    (counter_one_prescale_r[7:TIW_PRE_DIV_LO]),
		.init_i   (init1_r),
		.count_o  (cnt1),
		.end_o    (end1),
		.toggle_o (tog1)
	);

	// ==========================================================
	// Timer output pin
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port3_line_six_o <= 1'b0;
		end else begin
			case (tiw_out_sel_e'(mode_r[TIW_MODE_OUT_LO +: 2]))
				TIW_OUT_CNT0: port3_line_six_o <= tog0;
				TIW_OUT_CNT1: port3_line_six_o <= tog1;
				TIW_OUT_CLK:  port3_line_six_o <= int_clk_r;
				default:      port3_line_six_o <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Interrupt controller
	logic [5:0] req_set;
	logic [5:0] req_val;
	logic [2:0] int_id;
	logic [5:0] reg_wdata_q_r;

	// Bit order: 0 line two fall, 1 line three fall, 2 line one fall, 3 line two rise
	assign req_set = {end1, end0, rise_two, fall[0], fall[2], fall[1]};

	tiw_intc u_intc (
		.clock_i   (clock_i),
		.rst_b_i   (rst_b_i && !soft_rst),
		.set_i     (req_set),
		.sw_clr_i  (6'h00),
		.sw_wr_i   (req_wr_p),
		.sw_data_i (reg_wdata_q_r),
		.mask_i    (mask_r),
		.prio_i    (prio_r),
		.ack_i     (int_ack_i),
		.req_o     (req_val),
		.irq_o     (int_req_o),
		.id_o      (int_id),
		.vector_o  (int_vector_o)
	);

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_wdata_q_r <= 6'h00;
			int_disable_o <= 1'b1;
		end else begin
			if (reg_wr_i) begin
				reg_wdata_q_r <= reg_wdata_i[5:0];
			end
			int_disable_o <= !mask_r[TIW_MASK_GLOBAL];
		end
	end

	// ==========================================================
	// Read-back: counters live, prescalers and priority read as zero
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			if (reg_addr_i == TIW_ADDR_MODE) begin
				reg_rdata_o <= mode_r;
			end else if (reg_addr_i == TIW_ADDR_CNT1) begin
				reg_rdata_o <= cnt1;
			end else if (reg_addr_i == TIW_ADDR_CNT0) begin
				reg_rdata_o <= cnt0;
			end else if (reg_addr_i == TIW_ADDR_REQ) begin
				reg_rdata_o <= {2'b00, req_val};
			end else if (reg_addr_i == TIW_ADDR_MASK) begin
				reg_rdata_o <= mask_r;
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	// ==========================================================
	// Watchdog and power-on hold-off
	logic        wdt_en_r;
	logic [31:0] wdt_cnt_r;
	logic [31:0] por_cnt_r;
	logic        wdt_kick;

	assign wdt_kick = opcode_valid_i && opcode_i == TIW_WDT_OPCODE && !core_hold_o;
	assign soft_rst = sys_reset_o;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wdt_en_r    <= 1'b0;
			wdt_cnt_r   <= 32'd0;
			sys_reset_o <= 1'b0;
		end else begin
			sys_reset_o <= 1'b0;
			if (sys_reset_o) begin
				wdt_en_r  <= 1'b0;
				wdt_cnt_r <= 32'd0;
			end else if (wdt_kick) begin
				wdt_en_r  <= 1'b1;
				wdt_cnt_r <= 32'd0;
			end else if (wdt_en_r) begin
				if (wdt_cnt_r == 32'(WDT_CYCLES - 1)) begin
					sys_reset_o <= 1'b1;
				end else begin
					wdt_cnt_r <= wdt_cnt_r + 32'd1;
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			por_cnt_r   <= 32'd0;
			core_hold_o <= 1'b1;
		end else if (sys_reset_o) begin
			por_cnt_r   <= 32'd0;
			core_hold_o <= 1'b1;
		end else if (core_hold_o) begin
			if (por_cnt_r == 32'(POR_CYCLES - 1)) begin
				core_hold_o <= 1'b0;
			end else begin
				por_cnt_r <= por_cnt_r + 32'd1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/tiw_top_sva.sv ====
// Port-level assertion checker for the timer, interrupt and watchdog unit
`timescale 1ns/100ps
`default_nettype none
module tiw_top_sva
	import tiw_pkg::*;
#(
	parameter int POR_CYCLES = TIW_POR_CYCLES,
	parameter int WDT_CYCLES = TIW_WDT_CYCLES
) (
	input wire logic       clock_i,
	input wire logic       rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [7:0] opcode_i,
	input wire logic       opcode_valid_i,
	input wire logic       int_ack_i,
	input wire logic       port3_line_one_i,
	input wire logic       port3_line_two_i,
	input wire logic       port3_line_three_i,
	input wire logic       port3_line_six_o,
	input wire logic       int_req_o,
	input wire logic [3:0] int_vector_o,
	input wire logic       int_disable_o,
	input wire logic       core_hold_o,
	input wire logic       sys_reset_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// ==========
	// Cycle counters since kick and since hold start
	logic [31:0] kick_cnt_r;
	logic [31:0] hold_cnt_r;
	logic        wdt_on_r;
	wire logic   kick = opcode_valid_i && opcode_i == TIW_WDT_OPCODE;
	wire logic   rd_none = !(reg_addr_i inside {TIW_ADDR_MODE, TIW_ADDR_CNT1, TIW_ADDR_CNT0,
		TIW_ADDR_REQ, TIW_ADDR_MASK});
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			kick_cnt_r <= 32'h0;
			hold_cnt_r <= 32'h0;
			wdt_on_r   <= 1'b0;
		end else begin
			kick_cnt_r <= kick ? 32'h0 : kick_cnt_r + 32'h1;
			hold_cnt_r <= core_hold_o ? hold_cnt_r + 32'h1 : 32'h0;
			wdt_on_r   <= (wdt_on_r || kick) && !sys_reset_o;
		end
	end
	// ==========
	// Assertions
	rd_zero_a: assert property (reg_rd_i && rd_none |=> reg_rdata_o == 8'h00)
		else $error("unreadable place gave nonzero data");
	rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	rst_pulse_a: assert property (sys_reset_o |=> !sys_reset_o)
		else $error("timeout reset longer than one cycle");
	rst_hold_a: assert property (sys_reset_o |-> ##[0:2] core_hold_o)
		else $error("timeout did not restart hold");
	hold_len_a: assert property ($fell(core_hold_o) |->
		hold_cnt_r >= POR_CYCLES - 3 && hold_cnt_r <= POR_CYCLES + 3)
		else $error("hold length wrong");
	wdt_late_a: assert property (wdt_on_r |-> kick_cnt_r <= WDT_CYCLES + 4)
		else $error("watchdog failed to time out");
	wdt_early_a: assert property (sys_reset_o |-> wdt_on_r && kick_cnt_r >= WDT_CYCLES - 4)
		else $error("watchdog fired early or unarmed");
	grant_off_a: assert property (int_ack_i && int_req_o |-> ##[1:3] int_disable_o)
		else $error("grant left interrupts on");
	mask_off_a: assert property (reg_wr_i && reg_addr_i == TIW_ADDR_MASK && !reg_wdata_i[7]
		|-> ##[1:2] int_disable_o)
		else $error("global disable not seen");
	req_gate_a: assert property (int_disable_o && $past(int_disable_o) |-> !int_req_o)
		else $error("request while globally off");
	vec_range_a: assert property (int_req_o |-> !int_vector_o[0] && int_vector_o <= 4'hA)
		else $error("vector outside table");
	cover property (sys_reset_o);
	cover property (int_ack_i && int_req_o);
	cover property ($fell(core_hold_o));
	cover property (reg_rd_i && rd_none);
endmodule
bind tiw_top tiw_top_sva #(.POR_CYCLES(POR_CYCLES), .WDT_CYCLES(WDT_CYCLES)) sva_u (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .opcode_i(opcode_i),
	.opcode_valid_i(opcode_valid_i), .int_ack_i(int_ack_i), .port3_line_one_i(port3_line_one_i),
	.port3_line_two_i(port3_line_two_i), .port3_line_three_i(port3_line_three_i),
	.port3_line_six_o(port3_line_six_o), .int_req_o(int_req_o), .int_vector_o(int_vector_o),
	.int_disable_o(int_disable_o), .core_hold_o(core_hold_o), .sys_reset_o(sys_reset_o));
`default_nettype wire

// ==== verification/tiw_core_model.sv ====
// Model of the processor core and the port 3 input pins
`timescale 1ns/100ps
`default_nettype none
module tiw_core_model
	import tiw_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	input  wire logic       int_req_i,
	input  wire logic [3:0] int_vector_i,
	input  wire logic       core_hold_i,
	input  wire logic       ack_en_i,
	input  wire logic       slow_i,
	output logic            int_ack_o,
	output logic      [7:0] opcode_o,
	output logic            opcode_valid_o,
	output logic      [2:0] pins_o
);
	logic [2:0] wait_r;
	logic [3:0] vec_seen;
	int         acks;
	// Pins idle high
	initial begin
		pins_o = 3'h7;
		opcode_o = 8'h00;
		opcode_valid_o = 1'b0;
		int_ack_o = 1'b0;
		vec_seen = 4'h0;
		acks = 0;
	end
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			int_ack_o <= 1'b0;
			wait_r <= 3'h0;
		end else begin
			int_ack_o <= 1'b0;
			if (!int_req_i || !ack_en_i || core_hold_i || int_ack_o) begin
				wait_r <= 3'h0;
			end else if (wait_r >= (slow_i ? 3'h6 : 3'h2)) begin
				int_ack_o <= 1'b1;
				vec_seen <= int_vector_i;
				acks <= acks + 1;
				wait_r <= 3'h0;
			end else begin
				wait_r <= wait_r + 3'h1;
			end
		end
	end
	// Watchdog instruction, one cycle
	task automatic kick();
		opcode_o = TIW_WDT_OPCODE;
		opcode_valid_o = 1'b1;
		@(posedge clock_i);
		#1 opcode_valid_o = 1'b0;
		opcode_o = 8'h00;
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_tiw_top.sv ====
// Self-checking bench for the timer, interrupt and watchdog unit
`timescale 1ns/100ps
`default_nettype none
module tb_tiw_top;
	import tiw_pkg::*;
	localparam int POR = 50;
	localparam int WDT = 200;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, opc, d, q;
	logic wr = 1'b0, rd = 1'b0, ack, opv, six, irq, dis, hold, srst, srst_seen = 1'b0;
	logic ack_en = 1'b0, slow = 1'b0;
	logic [2:0] pins;
	logic [3:0] vec;
	logic [7:0] zro [5] = '{8'hF0, 8'hF3, 8'hF5, 8'hF9, 8'hF6};
	logic [7:0] lo [3] = '{8'h04, 8'h01, 8'h02};
	logic [7:0] hi [3] = '{8'h04, 8'h09, 8'h02};
	logic [7:0] ps [4] = '{8'h00, 8'h04, 8'h05, 8'h00};
	logic [7:0] pm [4] = '{8'h91, 8'h91, 8'h91, 8'h90};
	tiw_in_mode_e gm [3] = '{TIW_IN_GATE, TIW_IN_TRIG_NR, TIW_IN_TRIG_RT};
	int error_cnt = 0, comparisons = 0, cyc = 0, n, t;
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) cyc <= cyc + 1;
	always @(posedge clock_i) if (srst === 1'b1) srst_seen <= 1'b1;
	tiw_top #(.POR_CYCLES(POR), .WDT_CYCLES(WDT)) dut_u (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdat),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .opcode_i(opc), .opcode_valid_i(opv),
		.int_ack_i(ack), .port3_line_one_i(pins[0]), .port3_line_two_i(pins[1]),
		.port3_line_three_i(pins[2]), .port3_line_six_o(six), .int_req_o(irq),
		.int_vector_o(vec), .int_disable_o(dis), .core_hold_o(hold), .sys_reset_o(srst));
	tiw_core_model core_u (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .int_req_i(irq), .int_vector_i(vec),
		.core_hold_i(hold), .ack_en_i(ack_en), .slow_i(slow), .int_ack_o(ack), .opcode_o(opc),
		.opcode_valid_o(opv), .pins_o(pins));
	// ==========
	// Bus and check helpers
	task automatic step(int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wreg(logic [7:0] a, logic [7:0] v);
		addr = a;
		wdat = v;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		step(1);
	endtask
	task automatic rreg(logic [7:0] a, output logic [7:0] v);
		addr = a;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		step(1);
		v = rdat;
	endtask
	task automatic poll(int b, int lim);
		logic [7:0] v;
		for (int i = 0; i < lim; i++) begin
			rreg(TIW_ADDR_REQ, v);
			if (v[b] === 1'b1)
				break;
		end
	endtask
	task automatic pulse(int k);
		core_u.pins_o[k] = 1'b0;
		step(10);
		core_u.pins_o[k] = 1'b1;
		step(10);
	endtask
	function automatic int tcnt(int dv, int ld);
		return 4 * (dv == 0 ? 64 : dv) * (ld == 0 ? 256 : ld);
	endfunction
	function automatic int pick(logic [5:0] p, int s);
		for (int k = 0; k < 6; k++)
			if (p[(s + k) % 6])
				return (s + k) % 6;
		return 0;
	endfunction
	// Counter zero single pass, timed from the mode write
	task automatic run0(int dv, int ld);
		logic [7:0] v;
		logic s0;
		int e, t0, dif;
		e = tcnt(dv, ld);
		wreg(TIW_ADDR_REQ, 8'h00);
		wreg(TIW_ADDR_COUNTER_ZERO_PRESCALE, {dv[5:0], 2'b00});
		wreg(TIW_ADDR_CNT0, ld[7:0]);
		s0 = six;
		wreg(TIW_ADDR_MODE, 8'h43);
		t0 = cyc;
		if (ld > 2) begin
			step(e / 2);
			rreg(TIW_ADDR_CNT0, v);
			dif = ld - (cyc - t0) / (4 * dv) - v;
			chk("live count", dif >= -2 && dif <= 2, 1);
		end
		poll(4, e);
		chk("end time", cyc - t0 >= e - 4 && cyc - t0 <= e + 12, 1);
		chk("out toggle", six, !s0);
		rreg(TIW_ADDR_CNT0, v);
		chk("halted", v, 0);
		wreg(TIW_ADDR_REQ, 8'h00);
		step(e + 16);
		rreg(TIW_ADDR_REQ, v);
		chk("one pass", v[4], 0);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#2_000_000;
		error_cnt++;
		give_verdict();
	end
	// ==========
	// Main sequence
	initial begin
		void'($urandom(32'hF8091304));
		step(2);
		rst_b_i = 1'b1;
		chk("hold at start", hold, 1);
		chk("off at start", dis, 1);
		rreg(TIW_ADDR_REQ, d);
		chk("req reset", d, TIW_REQ_RST);
		rreg(TIW_ADDR_MASK, d);
		chk("mask reset", d, TIW_MASK_RST);
		for (n = 0; n < POR + 20 && hold === 1'b1; n++) step(1);
		chk("hold release", hold, 0);
		foreach (zro[i]) begin
			rreg(zro[i], d);
			chk("no readback", d, 8'h00);
		end
		repeat (4) begin
			t = $urandom;
			wreg(TIW_ADDR_MASK, t[7:0]);
			rreg(TIW_ADDR_MASK, d);
			chk("mask rw", d, t[7:0]);
		end
		wreg(TIW_ADDR_MASK, 8'h00);
		run0(1, 0);
		run0(0, 1);
		repeat (3) run0(1 + $urandom % 4, 1 + $urandom % 8);
		wreg(TIW_ADDR_COUNTER_ONE_PRESCALE, 8'h07);
		wreg(TIW_ADDR_CNT1, 8'h05);
		wreg(TIW_ADDR_MODE, 8'h0C);
		poll(5, 40);
		wreg(TIW_ADDR_REQ, 8'h00);
		t = cyc;
		poll(5, 40);
		chk("reload period", cyc - t >= 10 && cyc - t <= 24, 1);
		wreg(TIW_ADDR_MODE, 8'h00);
		rreg(TIW_ADDR_CNT1, d);
		step(30);
		rreg(TIW_ADDR_CNT1, q);
		chk("stopped", q, d);
		wreg(TIW_ADDR_MODE, 8'h08);
		step(6);
		rreg(TIW_ADDR_CNT1, q);
		chk("resumed", q !== d, 1);
		wreg(TIW_ADDR_MODE, 8'h04);
		rreg(TIW_ADDR_CNT1, q);
		chk("reloaded", q, 8'h05);
		wreg(TIW_ADDR_COUNTER_ONE_PRESCALE, 8'h04);
		wreg(TIW_ADDR_CNT1, 8'h03);
		wreg(TIW_ADDR_MODE, 8'h0C);
		wreg(TIW_ADDR_REQ, 8'h00);
		repeat (2) pulse(0);
		rreg(TIW_ADDR_REQ, d);
		chk("ext two", d[5], 0);
		pulse(0);
		rreg(TIW_ADDR_REQ, d);
		chk("ext three", d[5], 1);
		foreach (gm[i]) begin
			wreg(TIW_ADDR_REQ, 8'h00);
			wreg(TIW_ADDR_COUNTER_ONE_PRESCALE, 8'h04);
			wreg(TIW_ADDR_CNT1, 8'h01);
			wreg(TIW_ADDR_MODE, {2'b00, gm[i], 4'hC});
			pulse(0);
			step(20);
			rreg(TIW_ADDR_REQ, d);
			chk("gate trigger", d[5], 1);
		end
		wreg(TIW_ADDR_REQ, 8'h00);
		wreg(TIW_ADDR_COUNTER_ZERO_PRESCALE, 8'h05);
		wreg(TIW_ADDR_CNT0, 8'h02);
		wreg(TIW_ADDR_COUNTER_ONE_PRESCALE, 8'h06);
		wreg(TIW_ADDR_CNT1, 8'h02);
		wreg(TIW_ADDR_MODE, 8'h4F);
		step(10);
		rreg(TIW_ADDR_REQ, d);
		chk("cascade early", d[5], 0);
		step(12);
		rreg(TIW_ADDR_REQ, d);
		chk("cascade end", d[5], 1);
		wreg(TIW_ADDR_MODE, 8'h00);
		for (n = 0; n < 3; n++) begin
			wreg(TIW_ADDR_REQ, 8'h00);
			core_u.pins_o[n] = 1'b0;
			step(8);
			rreg(TIW_ADDR_REQ, d);
			chk("fall latch", d, lo[n]);
			core_u.pins_o[n] = 1'b1;
			step(8);
			rreg(TIW_ADDR_REQ, d);
			chk("rise latch", d, hi[n]);
			chk("masked quiet", irq, 0);
		end
		for (n = 0; n < 4; n++) begin
			wreg(TIW_ADDR_REQ, 8'h11);
			wreg(TIW_ADDR_PRIO, ps[n]);
			t = pick(6'h11 & pm[n][5:0], ps[n]);
			slow = n[0];
			ack_en = 1'b1;
			wreg(TIW_ADDR_MASK, pm[n]);
			for (int w = 0; w < 40 && core_u.acks == n; w++) step(1);
			ack_en = 1'b0;
			chk("grant vector", core_u.vec_seen, 2 * t);
			step(3);
			chk("grant disables", dis, 1);
			rreg(TIW_ADDR_REQ, d);
			chk("grant clears", d, 8'h11 & ~(8'h01 << t));
		end
		wreg(TIW_ADDR_MASK, 8'h55);
		core_u.kick();
		repeat (4) begin
			step(WDT / 2);
			core_u.kick();
		end
		chk("kept alive", srst_seen, 0);
		for (n = 0; n < WDT + 20 && srst_seen !== 1'b1; n++) step(1);
		chk("timeout", srst_seen, 1);
		step(2);
		chk("hold again", hold, 1);
		for (n = 0; n < POR + 20 && hold === 1'b1; n++) step(1);
		rreg(TIW_ADDR_MASK, d);
		chk("mask after timeout", d, TIW_MASK_RST);
		give_verdict();
	end
endmodule
`default_nettype wire
